// ===== core/ugit_global_events.sv
// Global event status, clear, endpoint reset strobes and line test control
`timescale 1ns/1ps
`include "ugit_defines.svh"

module ugit_global_events
  import ugit_pkg::*;
#(
  parameter int SUSPEND_CYCLES = `UGIT_SUSPEND_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        sof_token,
  input  wire logic        sof_is_micro,
  input  wire logic [10:0] sof_frame_num,
  input  wire logic        synth_sof,
  input  wire logic        synth_is_micro,
  input  wire logic        hs_handshake_ok,
  input  wire logic        bus_reset_done,
  input  wire logic        host_resume_done,
  input  wire logic        device_resume_sending,
  input  wire logic        line_j_pin,
  input  wire logic        bus_activity_pin,
  input  wire logic [6:0]  ep_pending,
  input  wire logic [5:0]  dma_pending,
  output logic             irq,
  output logic      [6:0]  ep_reset_pulse,
  output logic             speed_hs,
  output logic      [1:0]  speed_cfg,
  output logic             suspended,
  output logic             drive_j_test,
  output logic             drive_k_test,
  output logic             repeat_packet_test,
  output logic      [1:0]  opmode
);

  // ==========================================================================
  // Declarations
  logic [31:0]         enable_reg;
  logic [5:0]          test_reg;
  logic [31:0]         rdata_reg;
  logic [6:0]          ep_reset_reg;
  logic                speed_hs_reg;
  logic                speed_hs_next;
  logic [2:0]          micro_cnt_reg;
  logic [10:0]         frame_num_reg;
  logic [17:0]         idle_cnt_reg;
  logic                line_j_meta;
  logic                line_j_sync;
  logic                wake_meta;
  logic                wake_sync;
  logic                wake_seen_reg;
  logic                wake_toggle;
  logic                wake_armed;
  logic                wake_async;
  logic                wake_event;
  logic                suspend_event;
  logic                set_micro;
  logic                set_frame;
  logic [7:1]          flag_set;
  logic [7:1]          flag_clr;
  logic [7:1]          flags;
  logic [6:0]          ep_sum;
  logic [5:0]          dma_sum;
  logic [31:0]         status_word;
  logic [31:0]         fnum_word;
  ugit_link_state_type link_state_reg;
  ugit_speed_cfg_type  cfg;

  assign cfg = ugit_speed_cfg_type'(test_reg[`UGIT_TST_SPEED_LSB +: 2]);

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (rst) begin
      line_j_meta <= 1'b0;
      line_j_sync <= 1'b0;
    end else begin
      line_j_meta <= line_j_pin;
      line_j_sync <= line_j_meta;
    end
  end

  // ==========================================================================
  // Suspend detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_state_reg <= UGIT_LINK_ACTIVE;
      idle_cnt_reg   <= 18'h0;
    end else begin
      case (link_state_reg)
        UGIT_LINK_ACTIVE: begin
          if (!line_j_sync) begin
            idle_cnt_reg <= 18'h0;
          end else if (idle_cnt_reg == 18'(SUSPEND_CYCLES - 1)) begin
            idle_cnt_reg   <= 18'h0;
            link_state_reg <= UGIT_LINK_SUSPENDED;
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 18'h1;
          end
        end
        UGIT_LINK_SUSPENDED: begin
          if (!line_j_sync) begin
            link_state_reg <= UGIT_LINK_ACTIVE;
          end
        end
        default: begin
          link_state_reg <= UGIT_LINK_ACTIVE;
          idle_cnt_reg   <= 18'h0;
        end
      endcase
    end
  end

  assign suspend_event = (link_state_reg == UGIT_LINK_ACTIVE) && line_j_sync &&
                         (idle_cnt_reg == 18'(SUSPEND_CYCLES - 1));
  assign suspended     = (link_state_reg == UGIT_LINK_SUSPENDED);

  // ==========================================================================
  // Wake detection
  // The catcher runs on line activity, so a wake is held even with mclk off.
  assign wake_armed = suspended && !device_resume_sending;

  ugit_wake_catcher u_wake (
    .rst          (rst),
    .bus_activity (bus_activity_pin),
    .armed        (wake_armed),
    .wake_toggle  (wake_toggle)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_meta     <= 1'b0;
      wake_sync     <= 1'b0;
      wake_seen_reg <= 1'b0;
    end else begin
      wake_meta     <= wake_toggle;
      wake_sync     <= wake_meta;
      wake_seen_reg <= wake_sync;
    end
  end

  assign wake_event = wake_sync ^ wake_seen_reg;
  // Unclocked path: a pending toggle reaches the interrupt before mclk returns
  assign wake_async = (wake_toggle ^ wake_seen_reg) & enable_reg[`UGIT_BIT_WAKE];

  // ==========================================================================
  // Start of frame events
  // A frame start takes priority, so one event never raises both flags.
  assign set_frame = (sof_token && !sof_is_micro) || (synth_sof && !synth_is_micro);
  assign set_micro = ((sof_token && sof_is_micro) || (synth_sof && synth_is_micro)) && !set_frame;

  always_ff @(posedge mclk) begin
    if (rst) begin
      micro_cnt_reg <= 3'h0;
      frame_num_reg <= 11'h0;
    end else if (sof_token && sof_is_micro) begin
      micro_cnt_reg <= micro_cnt_reg + 3'h1;
    end else if (sof_token) begin
      frame_num_reg <= sof_frame_num;
      if (speed_hs_reg) begin
        micro_cnt_reg <= 3'h0;
      end
    end
  end

  // ==========================================================================
  // Speed selection
  always_comb begin
    case (cfg)
      UGIT_SPEED_FORCE_HS: speed_hs_next = 1'b1;
      UGIT_SPEED_FORCE_FS: speed_hs_next = 1'b0;
      default:             speed_hs_next = hs_handshake_ok;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      speed_hs_reg <= 1'b0;
    end else begin
      speed_hs_reg <= speed_hs_next;
    end
  end

  assign speed_hs = speed_hs_reg;

  // ==========================================================================
  // Sticky event flags
  always_comb begin
    flag_set = 7'h0;
    flag_set[`UGIT_BIT_SUSPEND]        = suspend_event;
    flag_set[`UGIT_BIT_MICRO_SOF]      = set_micro;
    flag_set[`UGIT_BIT_FRAME_SOF]      = set_frame;
    flag_set[`UGIT_BIT_BUS_RESET_DONE] = bus_reset_done;
    flag_set[`UGIT_BIT_WAKE]           = wake_event;
    flag_set[`UGIT_BIT_HOST_RSM_DONE]  = host_resume_done;
    flag_set[`UGIT_BIT_DEV_RSM_SEND]   = device_resume_sending;
  end

  assign flag_clr = (wr && addr == `UGIT_ADDR_EVENT_CLEAR) ? wdata[7:1] : 7'h0;

  generate
    for (genvar i = 1; i < 8; i++) begin : g_flag
      ugit_sticky_flag #(
        .RESET_VAL (1'b0)
      ) u_flag (
        .mclk (mclk),
        .rst  (rst),
        .set  (flag_set[i]),
        .clr  (flag_clr[i]),
        .flag (flags[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Summaries and interrupt
  assign ep_sum  = ep_pending & enable_reg[`UGIT_EP_LSB +: `UGIT_EP_COUNT];
  assign dma_sum = dma_pending & enable_reg[`UGIT_DMA_LSB +: `UGIT_DMA_COUNT];
  assign irq     = (|(flags & enable_reg[7:1])) | (|ep_sum) | (|dma_sum) | wake_async;

  // ==========================================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_reg <= `UGIT_ENABLE_RESET;
    end else begin
      if (wr && addr == `UGIT_ADDR_EVENT_ENABLE) begin
        enable_reg <= wdata & `UGIT_ENABLE_MASK;
      end
      // Bus reset re-arms its own enable; placed last so it wins a write
      if (bus_reset_done) begin
        enable_reg[`UGIT_BIT_BUS_RESET_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      test_reg <= `UGIT_TEST_RESET;
    end else if (wr && addr == `UGIT_ADDR_LINE_TEST) begin
      test_reg <= wdata[5:0];
    end
  end

  // Strobes last one cycle after the write to the endpoint reset address
  always_ff @(posedge mclk) begin
    if (rst) begin
      ep_reset_reg <= 7'h0;
    end else if (wr && addr == `UGIT_ADDR_EP_RESET) begin
      ep_reset_reg <= wdata[6:0];
    end else begin
      ep_reset_reg <= 7'h0;
    end
  end

  assign ep_reset_pulse     = ep_reset_reg;
  assign speed_cfg          = test_reg[`UGIT_TST_SPEED_LSB +: 2];
  assign drive_j_test       = test_reg[`UGIT_TST_DRIVE_J];
  assign drive_k_test       = test_reg[`UGIT_TST_DRIVE_K];
  assign repeat_packet_test = test_reg[`UGIT_TST_REPEAT_PKT];
  assign opmode             = test_reg[`UGIT_TST_RAW_LINE] ? `UGIT_OPMODE_RAW : `UGIT_OPMODE_NORMAL;

  // ==========================================================================
  // Register reads
  always_comb begin
    status_word = 32'h0;
    status_word[`UGIT_BIT_SPEED] = speed_hs_reg;
    status_word[7:1] = flags;
    status_word[`UGIT_EP_LSB +: `UGIT_EP_COUNT] = ep_sum;
    status_word[`UGIT_DMA_LSB +: `UGIT_DMA_COUNT] = dma_sum;
    fnum_word = 32'h0;
    fnum_word[`UGIT_FNUM_MICRO_LSB +: 3] = micro_cnt_reg;
    fnum_word[`UGIT_FNUM_FRAME_LSB +: 11] = frame_num_reg;
  end

  // Write-only and unmapped addresses read as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (rd) begin
      case (addr)
        `UGIT_ADDR_FRAME_COUNTER: rdata_reg <= fnum_word;
        `UGIT_ADDR_EVENT_ENABLE:  rdata_reg <= enable_reg;
        `UGIT_ADDR_EVENT_STATUS:  rdata_reg <= status_word;
        `UGIT_ADDR_LINE_TEST:     rdata_reg <= {26'h0, test_reg};
        default:                  rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign rdata = rdata_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_micro_token;
    sof_token && sof_is_micro;
  endsequence

  sequence s_hs_frame_token;
    sof_token && !sof_is_micro && speed_hs_reg;
  endsequence

  sequence s_ep_reset_write;
    wr && addr == `UGIT_ADDR_EP_RESET;
  endsequence

  a_speed_forced: assert property (
    cfg == UGIT_SPEED_FORCE_FS |=> !speed_hs
  ) else $error("speed flag high while full speed forced");

  a_speed_hs_force: assert property (
    cfg == UGIT_SPEED_FORCE_HS |=> status_word[`UGIT_BIT_SPEED]
  ) else $error("speed flag low while high speed forced");

  a_suspend_latch: assert property (
    suspend_event |=> flags[`UGIT_BIT_SUSPEND] && suspended
  ) else $error("suspend not latched after idle time");

  a_suspend_time: assert property (
    $rose(flags[`UGIT_BIT_SUSPEND]) |-> $past(idle_cnt_reg) == 18'(SUSPEND_CYCLES - 1)
  ) else $error("suspend flag set before idle time elapsed");

  a_irq_gated: assert property (
    (flags & enable_reg[7:1]) == 7'h0 && ep_sum == 7'h0 && dma_sum == 6'h0 && !wake_async |-> !irq
  ) else $error("interrupt raised without enabled source");

  a_irq_raised: assert property (
    |(flags & enable_reg[7:1]) |-> irq
  ) else $error("enabled pending flag did not raise interrupt");

  a_sof_exclusive: assert property (
    !(flag_set[`UGIT_BIT_MICRO_SOF] && flag_set[`UGIT_BIT_FRAME_SOF])
  ) else $error("micro and frame start raised together");

  a_micro_count: assert property (
    s_micro_token |=> micro_cnt_reg == $past(micro_cnt_reg) + 3'h1 && frame_num_reg == $past(frame_num_reg)
  ) else $error("micro-frame count not advanced");

  a_frame_load: assert property (
    s_hs_frame_token |=> micro_cnt_reg == 3'h0 && frame_num_reg == $past(sof_frame_num)
  ) else $error("frame number not loaded on frame start");

  a_flag_clear: assert property (
    wr && addr == `UGIT_ADDR_EVENT_CLEAR && wdata[`UGIT_BIT_FRAME_SOF] && !set_frame
      |=> !flags[`UGIT_BIT_FRAME_SOF]
  ) else $error("clear write did not clear frame flag");

  a_ep_reset_pulse: assert property (
    s_ep_reset_write |=> ep_reset_pulse == $past(wdata[6:0])
  ) else $error("endpoint reset strobe does not match write");

  a_test_raw_line: assert property (
    wr && addr == `UGIT_ADDR_LINE_TEST && wdata[`UGIT_TST_RAW_LINE] |=> opmode == `UGIT_OPMODE_RAW
  ) else $error("raw line mode not forced");

  a_test_drive_j: assert property (
    wr && addr == `UGIT_ADDR_LINE_TEST |=> drive_j_test == $past(wdata[`UGIT_TST_DRIVE_J])
  ) else $error("drive J test bit not applied");

endmodule : ugit_global_events

// ===== core/ugit_defines.svh
// Register map, field positions, reset values and timing counts of the global event block
`ifndef UGIT_DEFINES_SVH
`define UGIT_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define UGIT_ADDR_FRAME_COUNTER  32'hfff78004
`define UGIT_ADDR_EVENT_ENABLE   32'hfff78010
`define UGIT_ADDR_EVENT_STATUS   32'hfff78014
`define UGIT_ADDR_EVENT_CLEAR    32'hfff78018
`define UGIT_ADDR_EP_RESET       32'hfff7801c
`define UGIT_ADDR_LINE_TEST      32'hfff780e0

// ==========================================================================
// Field positions
`define UGIT_BIT_SPEED           0
`define UGIT_BIT_SUSPEND         1
`define UGIT_BIT_MICRO_SOF       2
`define UGIT_BIT_FRAME_SOF       3
`define UGIT_BIT_BUS_RESET_DONE  4
`define UGIT_BIT_WAKE            5
`define UGIT_BIT_HOST_RSM_DONE   6
`define UGIT_BIT_DEV_RSM_SEND    7
`define UGIT_EP_LSB              8
`define UGIT_EP_COUNT            7
`define UGIT_DMA_LSB             25
`define UGIT_DMA_COUNT           6
`define UGIT_FNUM_MICRO_LSB      0
`define UGIT_FNUM_FRAME_LSB      3
`define UGIT_TST_SPEED_LSB       0
`define UGIT_TST_DRIVE_J         2
`define UGIT_TST_DRIVE_K         3
`define UGIT_TST_REPEAT_PKT      4
`define UGIT_TST_RAW_LINE        5

// ==========================================================================
// Writable masks, reset values and line mode codes
`define UGIT_ENABLE_MASK         32'h7e007ffe
`define UGIT_ENABLE_RESET        32'h00000000
`define UGIT_TEST_RESET          6'h00
`define UGIT_OPMODE_RAW          2'h2
`define UGIT_OPMODE_NORMAL       2'h0

// ==========================================================================
// Timing
`define UGIT_CLK_KHZ             50000
`define UGIT_SUSPEND_MS          3
`define UGIT_SUSPEND_CYCLES      (`UGIT_SUSPEND_MS * `UGIT_CLK_KHZ)

`endif

// ===== core/ugit_pkg.sv
// Types shared by the global event block
package ugit_pkg;

  typedef enum logic [1:0] {
    UGIT_SPEED_AUTO     = 2'h0,
    UGIT_SPEED_RESERVED = 2'h1,
    UGIT_SPEED_FORCE_HS = 2'h2,
    UGIT_SPEED_FORCE_FS = 2'h3
  } ugit_speed_cfg_type;

  typedef enum logic [1:0] {
    UGIT_LINK_ACTIVE    = 2'b01,
    UGIT_LINK_SUSPENDED = 2'b10
  } ugit_link_state_type;

endpackage : ugit_pkg

// ===== core/ugit_sticky_flag.sv
// One sticky event flag: set by hardware, cleared by software, set wins
`timescale 1ns/1ps
module ugit_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  always_ff @(posedge mclk) begin
    if (rst) begin
      flag <= RESET_VAL;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule : ugit_sticky_flag

// ===== core/ugit_wake_catcher.sv
// Catches bus activity while suspended, with the controller clock stopped
`timescale 1ns/1ps
module ugit_wake_catcher (
  input  wire logic rst,
  input  wire logic bus_activity,
  input  wire logic armed,
  output logic      wake_toggle
);

  // ==========================================================================
  // Activity edge domain
  // Clocked by the filtered line activity itself so no controller edge is
  // needed. Armed is a level, high while suspended and no device resume is being sent.
  always_ff @(posedge bus_activity or posedge rst) begin
    if (rst) begin
      wake_toggle <= 1'b0;
    end else if (armed) begin
      wake_toggle <= ~wake_toggle;
    end
  end

endmodule : ugit_wake_catcher

// ===== test/ugit_host_model.sv
// Upstream host model: frame tokens, bus reset and resume ends, idle and wake activity
`timescale 1ns/1ps
module ugit_host_model (
  input  wire logic        mclk,
  output logic             sof_token,
  output logic             sof_is_micro,
  output logic      [10:0] sof_frame_num,
  output logic             bus_reset_done,
  output logic             host_resume_done,
  output logic             line_j_pin,
  output logic             bus_activity_pin
);
  initial begin
    sof_token = 1'b0;
    sof_is_micro = 1'b0;
    sof_frame_num = 11'h000;
    bus_reset_done = 1'b0;
    host_resume_done = 1'b0;
    line_j_pin = 1'b0;
    bus_activity_pin = 1'b0;
  end
  // ==========================================================================
  // Token fields are inverted once the token is gone, so a stale number never passes
  task sof(input logic m, input logic [10:0] n);
    @(posedge mclk);
    sof_token <= 1'b1;
    sof_is_micro <= m;
    sof_frame_num <= n;
    @(posedge mclk);
    sof_token <= 1'b0;
    sof_is_micro <= ~m;
    sof_frame_num <= ~n;
  endtask : sof
  task pulse(input logic is_reset);
    @(posedge mclk);
    if (is_reset) bus_reset_done <= 1'b1;
    else host_resume_done <= 1'b1;
    @(posedge mclk);
    bus_reset_done <= 1'b0;
    host_resume_done <= 1'b0;
  endtask : pulse
  task bus_idle(input logic b);
    @(posedge mclk);
    line_j_pin <= b;
  endtask : bus_idle
  // Filtered activity edge is asynchronous to the controller clock
  task activity();
    #3 bus_activity_pin = 1'b1;
    #5 bus_activity_pin = 1'b0;
  endtask : activity
endmodule : ugit_host_model

// ===== test/testbench.sv
// Self-checking bench of the global event block
`timescale 1ns/1ps
`include "ugit_defines.svh"
module testbench;
  localparam int SUSP = 20;
  logic        mclk = 0, rst = 1, wr = 0, rd = 0, synth_sof = 0, synth_is_micro = 0;
  logic        hs_handshake_ok = 0, device_resume_sending = 0;
  logic [31:0] addr = 0, wdata = 0, rdata, v;
  logic [6:0]  ep_pending = 0, ep_reset_pulse;
  logic [5:0]  dma_pending = 0;
  logic        sof_token, sof_is_micro, bus_reset_done, host_resume_done, line_j_pin, bus_activity_pin;
  logic [10:0] sof_frame_num;
  logic        irq, speed_hs, suspended, drive_j_test, drive_k_test, repeat_packet_test;
  logic [1:0]  speed_cfg, opmode;
  int          err_count = 0, total_checks = 0, cyc = 0;
  logic [2:0]  m;

  always #10 mclk = ~mclk;

  ugit_host_model host (.mclk, .sof_token, .sof_is_micro, .sof_frame_num, .bus_reset_done,
    .host_resume_done, .line_j_pin, .bus_activity_pin);
  ugit_global_events #(.SUSPEND_CYCLES(SUSP)) dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .sof_token, .sof_is_micro, .sof_frame_num, .synth_sof, .synth_is_micro, .hs_handshake_ok,
    .bus_reset_done, .host_resume_done, .device_resume_sending, .line_j_pin, .bus_activity_pin,
    .ep_pending, .dma_pending, .irq, .ep_reset_pulse, .speed_hs, .speed_cfg, .suspended,
    .drive_j_test, .drive_k_test, .repeat_packet_test, .opmode);

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rreg(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic synth(input logic mic);
    @(posedge mclk);
    synth_sof <= 1'b1;
    synth_is_micro <= mic;
    @(posedge mclk);
    synth_sof <= 1'b0;
  endtask : synth
  task automatic st(output logic [31:0] d);
    rreg(`UGIT_ADDR_EVENT_STATUS, d);
  endtask : st

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    st(v); chk(v, 32'h0);
    rreg(`UGIT_ADDR_EVENT_ENABLE, v); chk(v, 32'h0);
    rreg(`UGIT_ADDR_EVENT_CLEAR, v); chk(v, 32'h0);
    rreg(32'hfff78020, v); chk(v, 32'h0);
  endtask : t_reset
  task automatic t_sof();
    host.sof(1'b0, 11'h155);
    st(v); chk(v[3:2], 2'h2);
    rreg(`UGIT_ADDR_FRAME_COUNTER, v); chk(v[13:3], 11'h155);
    m = v[2:0];
    host.sof(1'b1, 11'h2aa);
    st(v); chk(v[3:2], 2'h3);
    rreg(`UGIT_ADDR_FRAME_COUNTER, v); chk(v[13:0], {11'h155, m + 3'h1});
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h0c);
    fork
      host.sof(1'b0, 11'h001);
      synth(1'b1);
    join
    st(v); chk(v[3:2], 2'h2);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h08);
    synth(1'b0);
    st(v); chk(v[3:2], 2'h2);
    synth(1'b1);
    st(v); chk(v[3:2], 2'h3);
  endtask : t_sof
  task automatic t_clear_irq();
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h0);
    st(v); chk(v[3:2], 2'h3);
    chk(irq, 1'b0);
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'hffffffff);
    rreg(`UGIT_ADDR_EVENT_ENABLE, v); chk(v, `UGIT_ENABLE_MASK);
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h08);
    chk(irq, 1'b1);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h08);
    chk(irq, 1'b0);
    st(v); chk(v[3:2], 2'h1);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h04);
  endtask : t_clear_irq
  task automatic t_summary();
    @(posedge mclk);
    ep_pending <= 7'h41;
    dma_pending <= 6'h21;
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h0);
    st(v); chk(v, 32'h0);
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h40004100);
    st(v); chk(v, 32'h40004100);
    chk(irq, 1'b1);
    @(posedge mclk);
    ep_pending <= 7'h0;
    dma_pending <= 6'h0;
    st(v); chk(v, 32'h0);
    chk(irq, 1'b0);
  endtask : t_summary
  task automatic t_events();
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h0);
    host.pulse(1'b1);
    st(v); chk(v[7:1], 7'h08);
    rreg(`UGIT_ADDR_EVENT_ENABLE, v); chk(v, 32'h10);
    host.pulse(1'b0);
    @(posedge mclk);
    device_resume_sending <= 1'b1;
    @(posedge mclk);
    device_resume_sending <= 1'b0;
    st(v); chk(v[7:1], 7'h68);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'hfe);
    st(v); chk(v[7:1], 7'h0);
  endtask : t_events
  task automatic t_suspend_wake();
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h22);
    host.bus_idle(1'b1);
    tick(SUSP - 4);
    chk({suspended, irq}, 2'h0);
    tick(10);
    chk({suspended, irq}, 2'h3);
    st(v); chk(v[1], 1'b1);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h02);
    @(posedge mclk);
    device_resume_sending <= 1'b1;
    host.activity();
    tick(5);
    chk(irq, 1'b0);
    st(v); chk(v[5], 1'b0);
    @(posedge mclk);
    device_resume_sending <= 1'b0;
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h80);
    host.activity();
    chk(irq, 1'b1);
    // Controller clock stays running here; the wake flag reaches status only after the synchroniser, so wait four cycles
    tick(4);
    st(v); chk(v[5], 1'b1);
    wreg(`UGIT_ADDR_EVENT_CLEAR, 32'h20);
    chk(irq, 1'b0);
    host.bus_idle(1'b0);
    tick(4);
    chk(suspended, 1'b0);
    wreg(`UGIT_ADDR_EVENT_ENABLE, 32'h0);
  endtask : t_suspend_wake
  task automatic t_ep_reset();
    wreg(`UGIT_ADDR_EP_RESET, 32'h41);
    chk(ep_reset_pulse, 7'h41);
    @(posedge mclk);
    #1 chk(ep_reset_pulse, 7'h0);
    wreg(`UGIT_ADDR_EP_RESET, 32'h0);
    chk(ep_reset_pulse, 7'h0);
  endtask : t_ep_reset
  task automatic t_test_reg();
    logic [1:0] cfg [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
    logic [3:0] hs = 4'b1011;
    hs_handshake_ok <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wreg(`UGIT_ADDR_LINE_TEST, {30'h0, cfg[i]});
      tick(2);
      chk({speed_cfg, speed_hs}, {cfg[i], hs[3 - i]});
      st(v); chk(v[0], hs[3 - i]);
    end
    wreg(`UGIT_ADDR_LINE_TEST, 32'h3e);
    chk({drive_j_test, drive_k_test, repeat_packet_test, opmode}, 5'h1e);
    rreg(`UGIT_ADDR_LINE_TEST, v); chk(v, 32'h3e);
    host.sof(1'b1, 11'h123);
    host.sof(1'b0, 11'h7ff);
    rreg(`UGIT_ADDR_FRAME_COUNTER, v); chk(v[13:0], {11'h7ff, 3'h0});
    wreg(`UGIT_ADDR_LINE_TEST, 32'h2);
    chk({drive_j_test, drive_k_test, repeat_packet_test, opmode}, 5'h0);
  endtask : t_test_reg

  // ==========================================================================
  // Verdict and hang guard
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    tick(10);
    rst <= 1'b0;
    t_reset();
    t_sof();
    t_clear_irq();
    t_summary();
    t_events();
    t_suspend_wake();
    t_ep_reset();
    t_test_reg();
    final_report();
  end
endmodule : testbench
